// *** logic/bdc_consts.svh ***
`ifndef BDC_CONSTS_SVH
`define BDC_CONSTS_SVH

// Device size selection codes
`define BDC_SIZE_256K       2'h0
`define BDC_SIZE_1M         2'h1
`define BDC_SIZE_4M         2'h2
// Row and column address widths per device size
`define BDC_ROWW_256K       9
`define BDC_ROWW_1M         10
`define BDC_ROWW_4M         11
// Transfer size codes, byte and word sizes
`define BDC_SIZ_BYTE        2'h1
`define BDC_SIZ_WORD        2'h2
// Cycle counts for refresh phases
`define BDC_REF_HOLD        2'h2
// Default synchroniser reset level, kept by the refresh request synchroniser
`define BDC_SYNC_RESET      1'h0
// Reset level for pins that idle high
`define BDC_SYNC_IDLE_HIGH  1'h1

`endif

// *** logic/bdc_pkg.sv ***
package bdc_pkg;

    // Controller states
    typedef enum logic [2:0] {
        BDC_IDLE,
        BDC_ROW,
        BDC_COL,
        BDC_WAIT,
        BDC_ACK,
        BDC_REF_CAS,
        BDC_REF_RAS,
        BDC_REF_END
    } bdc_state_t;

    // Strobes driven to the array
    typedef struct packed {
        logic       rasN;
        logic [1:0] casN;
        logic       weN;
        logic       oeN;
        logic       muxCol;
    } bdc_dram_t;

    // Processor request as seen by the controller
    typedef struct packed {
        logic        sel;
        logic        rdWr;
        logic [1:0]  siz;
        logic        a0;
        logic [23:0] addr;
    } bdc_req_t;

endpackage : bdc_pkg

// *** logic/bdc_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "bdc_consts.svh"

module bdc_sync #(
    // Pin idle level; reset there so no false edge follows reset
    parameter logic IDLE_LEVEL = `BDC_SYNC_RESET
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Asynchronous level in, filtered level out
    input  wire logic asyncIn,
    output logic      syncOut
);

    logic stage1_q;
    logic stage2_q;
    logic stage3_q;

    // Three-stage chain; output moves when stages two and three agree
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1_q <= IDLE_LEVEL;
            stage2_q <= IDLE_LEVEL;
            stage3_q <= IDLE_LEVEL;
            syncOut  <= IDLE_LEVEL;
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            if (stage2_q == stage3_q) begin
                syncOut <= stage3_q;
            end
        end
    end

endmodule : bdc_sync

`default_nettype wire

// *** logic/bdc_dram_ctrl.sv ***
// Operation
// - Serve two sixteen-bit banks of four x4 devices each, 4 Mbytes default.
// - Drive row, column, write, output strobes and address mux select from FSM.
// - Add exactly one wait state to every access before acknowledging.
// - Accept byte, word, long accesses; byte writes enable only addressed lane.
// - Support 256K x4, 1M x4 and 4M x4 devices by changing address multiplexing.
// - Each timer refresh request runs a column-before-row refresh cycle.
// - Respond only to cycles qualified by chip select seven.
// - Return the size acknowledge ending each cycle, as a 16-bit port.
`timescale 1ns/1ns
`default_nettype none
`include "bdc_consts.svh"

module bdc_dram_ctrl (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    // Processor bus, asynchronous to the controller
    input  wire logic               addrStrobeN,
    input  wire logic               dataStrobeN,
    input  wire logic               memory_chip_select_seven_n,
    input  wire logic               readNotWrite,
    input  wire logic [1:0]         transferSize,
    input  wire logic [23:0]        busAddr,
    output logic [1:0]              transfer_size_acknowledge_n,
    // Refresh request from timer
    input  wire logic               refreshReq,
    // Strap: device size selection
    input  wire logic [1:0]         deviceSize,
    // DRAM array
    output logic [1:0]              rasN,
    output logic [1:0]              casN,
    output logic                    weN,
    output logic                    oeN,
    output logic                    muxCol,
    output logic [10:0]             dramAddr,
    output logic [3:0]              refreshCount
);

    logic              asSync;
    logic              dsSync;
    logic              csSync;
    logic              refSync;
    logic              refPrev_q;
    logic              refPend_q;
    bdc_pkg::bdc_state_t state_q;
    bdc_pkg::bdc_req_t req_q;
    logic [1:0]        size_q;
    logic              bank;
    logic [21:0]       lin;
    logic [10:0]       rowAddr;
    logic [10:0]       colAddr;
    logic [1:0]        laneCas;
    logic              refStart;

    // Pin synchronisers; strobes and select reset to their idle high level
    bdc_sync #(.IDLE_LEVEL(`BDC_SYNC_IDLE_HIGH)) uAs (.clk_sys(clk_sys), .reset_n(reset_n),
                   .asyncIn(addrStrobeN), .syncOut(asSync));
    bdc_sync #(.IDLE_LEVEL(`BDC_SYNC_IDLE_HIGH)) uDs (.clk_sys(clk_sys), .reset_n(reset_n),
                   .asyncIn(dataStrobeN), .syncOut(dsSync));
    bdc_sync #(.IDLE_LEVEL(`BDC_SYNC_IDLE_HIGH)) uCs (.clk_sys(clk_sys), .reset_n(reset_n),
                   .asyncIn(memory_chip_select_seven_n), .syncOut(csSync));
    bdc_sync uRef (.clk_sys(clk_sys), .reset_n(reset_n), .asyncIn(refreshReq),
                   .syncOut(refSync));

    // Strap captured on every cycle spent in BDC_IDLE
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            size_q <= `BDC_SIZE_1M;
        end else if (state_q == bdc_pkg::BDC_IDLE) begin
            size_q <= deviceSize;
        end
    end

    // Rising edge of refresh request held pending; set wins over clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            refPrev_q <= 1'h0;
            refPend_q <= 1'h0;
        end else begin
            refPrev_q <= refSync;
            if (refSync && !refPrev_q) begin
                refPend_q <= 1'h1;
            end else if (state_q == bdc_pkg::BDC_REF_CAS) begin
                refPend_q <= 1'h0;
            end
        end
    end

    assign refStart = refPend_q;

    // Request latched on every idle cycle; select flag qualified by chip select seven
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= '0;
        end else if (state_q == bdc_pkg::BDC_IDLE) begin
            req_q.sel  <= !asSync && !csSync;
            req_q.rdWr <= readNotWrite;
            req_q.siz  <= transferSize;
            req_q.a0   <= busAddr[0];
            req_q.addr <= busAddr;
        end
    end

    // Linear halfword address; bank is top bit for the fitted size
    assign lin = req_q.addr[22:1];
    always_comb begin
        rowAddr = 11'h000;
        colAddr = 11'h000;
        bank    = 1'h0;
        // Mux split per device size, and
        case (size_q)
            `BDC_SIZE_256K: begin
                colAddr = {2'h0, lin[8:0]};
                rowAddr = {2'h0, lin[17:9]};
                bank    = lin[18];
            end
            `BDC_SIZE_4M: begin
                colAddr = lin[10:0];
                rowAddr = lin[21:11];
                bank    = req_q.addr[23];
            end
            default: begin
                colAddr = {1'h0, lin[9:0]};
                rowAddr = {1'h0, lin[19:10]};
                bank    = lin[20];
            end
        endcase
    end

    // Byte lanes: byte writes strobe one lane, reads and words both
    always_comb begin
        laneCas = 2'h3;
        if (!req_q.rdWr && req_q.siz == `BDC_SIZ_BYTE) begin
            laneCas = req_q.a0 ? 2'h1 : 2'h2;
        end
    end

    // Main state machine; refresh has priority only between accesses
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= bdc_pkg::BDC_IDLE;
        end else begin
            case (state_q)
                bdc_pkg::BDC_IDLE: begin
                    if (refStart) begin
                        state_q <= bdc_pkg::BDC_REF_CAS;
                    end else if (!asSync && !csSync) begin
                        state_q <= bdc_pkg::BDC_ROW;
                    end
                end
                bdc_pkg::BDC_ROW:  state_q <= bdc_pkg::BDC_COL;
                bdc_pkg::BDC_COL:  state_q <= bdc_pkg::BDC_WAIT;
                bdc_pkg::BDC_WAIT: state_q <= bdc_pkg::BDC_ACK;
                bdc_pkg::BDC_ACK: begin
                    if (asSync && dsSync) begin
                        state_q <= bdc_pkg::BDC_IDLE;
                    end
                end
                bdc_pkg::BDC_REF_CAS: state_q <= bdc_pkg::BDC_REF_RAS;
                bdc_pkg::BDC_REF_RAS: state_q <= bdc_pkg::BDC_REF_END;
                default:              state_q <= bdc_pkg::BDC_IDLE;
            endcase
        end
    end

    // Array strobes, all registered
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rasN     <= 2'h3;
            casN     <= 2'h3;
            weN      <= 1'h1;
            oeN      <= 1'h1;
            muxCol   <= 1'h0;
            dramAddr <= 11'h000;
        end else begin
            case (state_q)
                bdc_pkg::BDC_IDLE: begin
                    rasN     <= 2'h3;
                    casN     <= 2'h3;
                    weN      <= 1'h1;
                    oeN      <= 1'h1;
                    muxCol   <= 1'h0;
                    dramAddr <= rowAddr;
                end
                bdc_pkg::BDC_ROW: begin
                    rasN     <= bank ? 2'h1 : 2'h2;
                    weN      <= req_q.rdWr;
                    muxCol   <= 1'h1;
                    dramAddr <= colAddr;
                end
                bdc_pkg::BDC_COL: begin
                    casN <= ~laneCas;
                    oeN  <= !req_q.rdWr;
                end
                bdc_pkg::BDC_REF_CAS: begin
                    casN <= 2'h0;
                end
                bdc_pkg::BDC_REF_RAS: begin
                    rasN <= 2'h0;
                end
                bdc_pkg::BDC_REF_END: begin
                    casN <= 2'h3;
                end
                default: begin
                end
            endcase
        end
    end

    // Size acknowledge: 16-bit port code, held until strobe negates
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            transfer_size_acknowledge_n <= 2'h3;
        end else if (state_q == bdc_pkg::BDC_WAIT && req_q.sel) begin
            transfer_size_acknowledge_n <= 2'h1;
        end else if (state_q != bdc_pkg::BDC_ACK || (asSync && dsSync)) begin
            transfer_size_acknowledge_n <= 2'h3;
        end
    end

    // Completed refresh cycles, saturating, for the power-up hold-off
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            refreshCount <= 4'h0;
        end else if (state_q == bdc_pkg::BDC_REF_END && refreshCount != 4'hF) begin
            refreshCount <= refreshCount + 4'h1;
        end
    end

endmodule : bdc_dram_ctrl

`default_nettype wire

// *** bench/bdc_dram_chk.sv ***
`timescale 1ns/1ns
`default_nettype none

module bdc_dram_chk (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // Processor bus
    input wire logic        addrStrobeN,
    input wire logic        memory_chip_select_seven_n,
    input wire logic [1:0]  transferSize,
    input wire logic [23:0] busAddr,
    input wire logic [1:0]  transfer_size_acknowledge_n,
    // Array strobes
    input wire logic [1:0]  rasN,
    input wire logic [1:0]  casN,
    input wire logic        weN,
    input wire logic        oeN,
    input wire logic        muxCol,
    input wire logic [3:0]  refreshCount
);
    logic [1:0] ackN;

    // Short alias for the acknowledge pair
    assign ackN = transfer_size_acknowledge_n;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_ackCode; ackN != 2'h3 |-> ackN == 2'h1; endproperty
    a_ackCode: assert property (p_ackCode) else $error("ack code wrong");
    property p_ackHold; ackN == 2'h1 && !addrStrobeN |=> ackN == 2'h1; endproperty
    a_ackHold: assert property (p_ackHold) else $error("ack dropped early");
    // Ack starts on the upper bit falling; the lower bit stays high
    property p_cs; $fell(ackN[1]) |-> !memory_chip_select_seven_n; endproperty
    a_cs: assert property (p_cs) else $error("ack without select");
    // Row, column, one wait state, then the acknowledge
    property p_wait;
        $fell(&rasN) && casN == 2'h3 |-> ackN == 2'h3 [*2] ##1 ackN == 2'h1;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state count wrong");
    property p_cbr; $fell(&rasN) && $past(casN) == 2'h0 |-> rasN == 2'h0; endproperty
    a_cbr: assert property (p_cbr) else $error("refresh row strobe wrong");
    property p_mux; casN != 2'h3 && ^rasN |-> muxCol; endproperty
    a_mux: assert property (p_mux) else $error("column select low");
    property p_lane;
        !weN && casN != 2'h3 && transferSize == 2'h1 |-> casN == {busAddr[0], !busAddr[0]};
    endproperty
    a_lane: assert property (p_lane) else $error("byte lane wrong");
    property p_refIso; rasN == 2'h0 |-> weN && oeN && ackN == 2'h3; endproperty
    a_refIso: assert property (p_refIso) else $error("access during refresh");
    property p_count;
        refreshCount != $past(refreshCount) |-> refreshCount == $past(refreshCount) + 4'h1;
    endproperty
    a_count: assert property (p_count) else $error("refresh count step wrong");
    c_read: cover property ($fell(oeN));
    c_write: cover property ($fell(weN));
    c_ref: cover property (rasN == 2'h0);
endmodule : bdc_dram_chk

bind bdc_dram_ctrl bdc_dram_chk bdc_dram_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .addrStrobeN(addrStrobeN), .memory_chip_select_seven_n(memory_chip_select_seven_n),
    .transferSize(transferSize), .busAddr(busAddr), .rasN(rasN), .casN(casN),
    .transfer_size_acknowledge_n(transfer_size_acknowledge_n), .weN(weN), .oeN(oeN),
    .muxCol(muxCol), .refreshCount(refreshCount));

`default_nettype wire

// *** bench/bdc_far_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module bdc_far_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Timer trigger and request
    input  wire logic       fire,
    output logic            refreshReq,
    // Array strobes watched
    input  wire logic [1:0] rasN,
    input  wire logic [1:0] casN,
    output logic [3:0]      cbrCount
);
    logic [2:0] hold_q;
    logic [1:0] ras_q;

    // Timer pulse, stretched past the synchroniser
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) hold_q <= 3'h0;
        else if (fire) hold_q <= 3'h4;
        else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    end
    assign refreshReq = hold_q != 3'h0;

    // Array: rows opened with columns already low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ras_q <= 2'h3;
            cbrCount <= 4'h0;
        end else begin
            ras_q <= rasN;
            // Both rows opening while both columns are already low
            if (ras_q == 2'h3 && rasN == 2'h0 && casN == 2'h0) begin
                cbrCount <= cbrCount + 4'h1;
            end
        end
    end
endmodule : bdc_far_model

`default_nettype wire

// *** bench/test_board_dram_controller.sv ***
`timescale 1ns/1ns
`default_nettype none

module test_board_dram_controller;
    logic        clk_sys, reset_n, asN, csN, rnw, fire, refreshReq, weN, oeN, muxCol;
    logic [1:0]  siz, devSize, ackN, rasN, casN, ack, lane, rasSeen;
    logic [23:0] addr;
    logic [10:0] dramAddr, rowSeen, colSeen;
    logic [3:0]  refreshCount, cbrCount;
    logic        sawOe;
    int          errors, checks_done;

    bdc_dram_ctrl bdc_dram_ctrl_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .addrStrobeN(asN), .dataStrobeN(asN), .memory_chip_select_seven_n(csN),
        .readNotWrite(rnw), .transferSize(siz), .busAddr(addr),
        .transfer_size_acknowledge_n(ackN), .refreshReq(refreshReq), .deviceSize(devSize),
        .rasN(rasN), .casN(casN), .weN(weN), .oeN(oeN), .muxCol(muxCol),
        .dramAddr(dramAddr), .refreshCount(refreshCount));
    bdc_far_model bdc_far_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .fire(fire),
        .refreshReq(refreshReq), .rasN(rasN), .casN(casN), .cbrCount(cbrCount));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [3:0] expv, input logic [3:0] gotv);
        checks_done++;
        if (gotv !== expv) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, expv, gotv);
        end
    endtask : check

    // Compare of a multiplexed array address
    task automatic check_addr(input string what, input logic [10:0] expv,
                              input logic [10:0] gotv);
        checks_done++;
        if (gotv !== expv) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, expv, gotv);
        end
    endtask : check_addr

    // One bus cycle; held until acknowledged
    task automatic access(input logic rd, input logic [1:0] sz, input logic [23:0] a);
        ack = 2'h3;
        lane = 2'h3;
        sawOe = 1'b0;
        rasSeen = 2'h3;
        rowSeen = 11'h7FF;
        colSeen = 11'h7FF;
        @(negedge clk_sys);
        rnw = rd;
        siz = sz;
        addr = a;
        asN = 1'b0;
        for (int i = 0; i < 40 && ack == 2'h3; i++) begin
            @(negedge clk_sys);
            if (!weN && casN != 2'h3) lane = casN;
            if (!oeN) sawOe = 1'b1;
            // Last address before the row strobe falls, then the column address
            if (rasN == 2'h3) rowSeen = dramAddr;
            if (muxCol) colSeen = dramAddr;
            if (rasN != 2'h3) rasSeen = rasN;
            if (ackN != 2'h3) ack = ackN;
        end
        asN = 1'b1;
        for (int i = 0; i < 20 && ackN != 2'h3; i++) @(negedge clk_sys);
        repeat (2) @(negedge clk_sys);
    endtask : access

    task automatic pulse;
        @(negedge clk_sys);
        fire = 1'b1;
        @(negedge clk_sys);
        fire = 1'b0;
        repeat (16) @(negedge clk_sys);
    endtask : pulse

    // Eight refreshes before any access
    task automatic t_powerUp;
        repeat (8) pulse();
        check("refreshCount", 4'h8, refreshCount);
        check("cbrCount", 4'h8, cbrCount);
    endtask : t_powerUp

    // One word read at a given device size, row, column and bank checked
    task automatic size_read(input logic [1:0] sz, input logic [10:0] expRow,
                             input logic [10:0] expCol, input logic [3:0] expRas);
        devSize = sz;
        access(1'b1, 2'h2, 24'h2AAAAA);
        check("ack", 4'h1, {2'h0, ack});
        check("sawOe", 4'h1, {3'h0, sawOe});
        check_addr("rowAddr", expRow, rowSeen);
        check_addr("colAddr", expCol, colSeen);
        check("bankRas", expRas, {2'h0, rasSeen});
    endtask : size_read

    // Word read at every device size
    task automatic t_sizes;
        size_read(2'h0, 11'h0AA, 11'h155, 4'h1);
        size_read(2'h1, 11'h155, 11'h155, 4'h1);
        size_read(2'h2, 11'h2AA, 11'h555, 4'h2);
    endtask : t_sizes

    // Lanes for byte, word and long writes
    task automatic t_lanes;
        access(1'b0, 2'h1, 24'h000010);
        check("laneByte0", 4'h1, {2'h0, lane});
        access(1'b0, 2'h1, 24'h000011);
        check("laneByte1", 4'h2, {2'h0, lane});
        access(1'b0, 2'h2, 24'h000020);
        check("laneWord", 4'h0, {2'h0, lane});
        access(1'b0, 2'h0, 24'h000024);
        check("laneLong", 4'h0, {2'h0, lane});
    endtask : t_lanes

    // Unselected cycle is ignored
    task automatic t_noSelect;
        csN = 1'b1;
        access(1'b1, 2'h2, 24'h000040);
        csN = 1'b0;
        // Let the strobe settle high before the select is seen again
        repeat (4) @(negedge clk_sys);
        check("ackUnselected", 4'h3, {2'h0, ack});
    endtask : t_noSelect

    // Refresh and access requested together
    task automatic t_collide;
        fork
            access(1'b1, 2'h2, 24'h000080);
            pulse();
        join
        // Pending refresh runs after the access; give it room to end
        repeat (4) @(negedge clk_sys);
        check("ackCollide", 4'h1, {2'h0, ack});
        check("refreshCount", 4'h9, refreshCount);
    endtask : t_collide

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        errors = 0;
        checks_done = 0;
        reset_n = 1'b0;
        asN = 1'b1;
        csN = 1'b0;
        rnw = 1'b1;
        siz = 2'h2;
        addr = 24'h000000;
        fire = 1'b0;
        devSize = 2'h1;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        t_powerUp();
        t_sizes();
        t_lanes();
        t_noSelect();
        t_collide();
        tally_and_finish();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        tally_and_finish();
    end
endmodule : test_board_dram_controller

`default_nettype wire
